//--- core/mdf_chan.sv
// One channel of the third-order comb decimator with saturating output.
`timescale 1ns/1ps
`default_nettype none
module mdf_chan (
   input wire logic clk_i,
   input wire logic reset_n_i,
   mdf_tick_if.chan tk,
   input wire logic bit_i,
   output logic [mdf_pkg::WORD_W-1:0] word_o
);
   import mdf_pkg::*;

   typedef struct packed {
      logic signed [ACC_W-1:0] i1;
      logic signed [ACC_W-1:0] i2;
      logic signed [ACC_W-1:0] i3;
      logic signed [ACC_W-1:0] d1;
      logic signed [ACC_W-1:0] d2;
      logic signed [ACC_W-1:0] d3;
      logic [WORD_W-1:0] word;
   } mdf_chan_st_t;

   mdf_chan_st_t st_reg;
   mdf_chan_st_t st_next;
   logic signed [ACC_W-1:0] smp;
   logic signed [ACC_W-1:0] c1;
   logic signed [ACC_W-1:0] c2;
   logic signed [ACC_W-1:0] c3;
   logic signed [ACC_W-1:0] scaled;
   logic ovf;
   logic [WORD_W-1:0] sat;

   always_comb begin
      st_next = st_reg;
      smp = bit_i ? ACC_W'(1) : '1;
      // Symmetric comb-integrator response keeps a constant group delay.
      c1 = st_reg.i3 - st_reg.d1;
      c2 = c1 - st_reg.d2;
      c3 = c2 - st_reg.d3;
      scaled = tk.hr ? (c3 <<< SHIFT_HR) : (c3 <<< SHIFT_STD);
      ovf = scaled[ACC_W-1:WORD_W-1] != {(ACC_W-WORD_W+1){scaled[ACC_W-1]}};
      // Results beyond full scale clip instead of wrapping.
      sat = ovf ? (scaled[ACC_W-1] ? NEG_FULL : POS_FULL) : scaled[WORD_W-1:0];
      if (tk.clr) begin
         st_next = '0;
      end else begin
         if (tk.tick) begin
            st_next.i1 = st_reg.i1 + smp;
            st_next.i2 = st_reg.i2 + st_reg.i1;
            st_next.i3 = st_reg.i3 + st_reg.i2;
         end
         if (tk.dec) begin
            st_next.d1 = st_reg.i3;
            st_next.d2 = c1;
            st_next.d3 = c2;
            st_next.word = sat;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign word_o = st_reg.word;

   chk_sat_high: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      tk.dec && !tk.clr && ovf && !scaled[ACC_W-1] |=> word_o == POS_FULL)
      else $error("Positive overflow did not clip to full scale.");
   chk_sat_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      tk.dec && !tk.clr && ovf && scaled[ACC_W-1] |=> word_o == NEG_FULL)
      else $error("Negative overflow did not clip to full scale.");
endmodule : mdf_chan
`default_nettype wire

//--- core/mdf_top.sv
// Modulator clock divider, shared decimation timing and the channel filters.
`timescale 1ns/1ps
`default_nettype none
module mdf_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [1:0] mode_i,
   input wire logic clock_divide_select_i,
   input wire logic realign_n_i,
   input wire logic [mdf_pkg::NUM_CHAN-1:0] mod_bits_i,
   output logic mod_clk_o,
   output logic [mdf_pkg::NUM_CHAN-1:0][mdf_pkg::WORD_W-1:0] data_o,
   output logic data_valid_o,
   output logic settled_o
);
   import mdf_pkg::*;

   typedef struct packed {
      logic [1:0] mode_s1;
      logic [1:0] mode_s2;
      logic cds_s1;
      logic cds_s2;
      logic rl_s1;
      logic rl_s2;
      logic [NUM_CHAN-1:0] bits_s1;
      logic [NUM_CHAN-1:0] bits_s2;
      logic [1:0] mode_prev;
      logic cds_prev;
      logic [5:0] div_cnt;
      logic [7:0] dec_cnt;
      logic [6:0] settle_cnt;
      mdf_phase_t phase;
      logic tick;
      logic dec;
      logic mclk;
      logic valid;
      logic settled;
   } mdf_top_st_t;

   mdf_top_st_t st_reg;
   mdf_top_st_t st_next;
   logic [5:0] div_sel;
   logic [7:0] osr_sel;
   logic [6:0] settle_sel;
   logic changed;
   logic clr;

   mdf_tick_if tk ();

   always_comb begin
      // Divider ratio per mode and divide select.
      case (mdf_mode_t'(st_reg.mode_s2))
         MODE_LOW_POWER: div_sel = st_reg.cds_s2 ? DIV_MID : DIV_FAST;
         MODE_LOW_SPEED: div_sel = st_reg.cds_s2 ? DIV_SLOW : DIV_MID;
         default: div_sel = DIV_FAST;
      endcase
      if (mdf_mode_t'(st_reg.mode_s2) == MODE_HIGH_RES) begin
         osr_sel = OSR_HR;
         settle_sel = SETTLE_HR;
      end else begin
         osr_sel = OSR_STD;
         settle_sel = SETTLE_STD;
      end
   end

   assign changed = (st_reg.mode_s2 != st_reg.mode_prev) || (st_reg.cds_s2 != st_reg.cds_prev);
   assign clr = !st_reg.rl_s2 || changed;

   always_comb begin
      st_next = st_reg;
      st_next.mode_s1 = mode_i;
      st_next.mode_s2 = st_reg.mode_s1;
      st_next.cds_s1 = clock_divide_select_i;
      st_next.cds_s2 = st_reg.cds_s1;
      st_next.rl_s1 = realign_n_i;
      st_next.rl_s2 = st_reg.rl_s1;
      st_next.bits_s1 = mod_bits_i;
      st_next.bits_s2 = st_reg.bits_s1;
      st_next.mode_prev = st_reg.mode_s2;
      st_next.cds_prev = st_reg.cds_s2;
      st_next.tick = 1'b0;
      st_next.dec = 1'b0;
      st_next.valid = st_reg.dec && !clr;
      if (clr) begin
         // Halt or restart with counters cleared.
         st_next.div_cnt = '0;
         st_next.dec_cnt = '0;
         st_next.settle_cnt = '0;
         st_next.phase = st_reg.rl_s2 ? ST_SETTLING : ST_HALT;
      end else begin
         case (st_reg.phase)
            ST_HALT: st_next.phase = ST_SETTLING;
            ST_SETTLING: begin
               if (st_reg.dec) begin
                  st_next.settle_cnt = st_reg.settle_cnt + 7'h01;
                  if (st_next.settle_cnt == settle_sel) begin
                     st_next.phase = ST_SETTLED;
                  end
               end
            end
            ST_SETTLED: st_next.phase = ST_SETTLED;
            default: st_next.phase = ST_HALT;
         endcase
         // One sample per modulator period.
         if (st_reg.div_cnt == div_sel - 6'h01) begin
            st_next.div_cnt = '0;
            st_next.tick = 1'b1;
         end else begin
            st_next.div_cnt = st_reg.div_cnt + 6'h01;
         end
         if (st_next.tick) begin
            if (st_reg.dec_cnt == osr_sel - 8'h01) begin
               st_next.dec_cnt = '0;
               st_next.dec = 1'b1;
            end else begin
               st_next.dec_cnt = st_reg.dec_cnt + 8'h01;
            end
         end
      end
      // The high half tracks the counter from its first cleared cycle on.
      st_next.mclk = st_next.div_cnt < (div_sel >> 1);
      st_next.settled = st_next.phase == ST_SETTLED;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Every channel sees the same clear, sample and output strobes.
   assign tk.tick = st_reg.tick;
   assign tk.dec = st_reg.dec;
   assign tk.clr = clr;
   assign tk.hr = mdf_mode_t'(st_reg.mode_s2) == MODE_HIGH_RES;

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      mdf_chan u_chan (
         .clk_i(clk_i),
         .reset_n_i(reset_n_i),
         .tk(tk),
         .bit_i(st_reg.bits_s2[g]),
         .word_o(data_o[g])
      );
   end

   assign mod_clk_o = st_reg.mclk;
   assign data_valid_o = st_reg.valid;
   assign settled_o = st_reg.settled;

   logic [5:0] h_cyc;
   logic h_tick_seen;
   logic [7:0] h_tk;
   logic h_dec_seen;
   logic [6:0] h_dec;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || clr) begin
         h_cyc <= '0;
         h_tick_seen <= 1'b0;
         h_tk <= '0;
         h_dec_seen <= 1'b0;
         h_dec <= '0;
      end else begin
         h_cyc <= st_reg.tick ? 6'h01 : h_cyc + 6'h01;
         h_tick_seen <= h_tick_seen || st_reg.tick;
         if (st_reg.dec) begin
            h_tk <= 8'h01;
            h_dec_seen <= 1'b1;
            h_dec <= h_dec + 7'h01;
         end else if (st_reg.tick) begin
            h_tk <= h_tk + 8'h01;
         end
      end
   end

   chk_div_ratio: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      st_reg.tick && h_tick_seen && !clr |-> h_cyc == div_sel)
      else $error("Modulator period does not match the selected divider.");
   chk_osr_std: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      st_reg.dec && h_dec_seen && !clr && !tk.hr |-> h_tk == OSR_STD)
      else $error("Standard mode did not decimate by 64.");
   chk_osr_hr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      st_reg.dec && h_dec_seen && !clr && tk.hr |-> h_tk == OSR_HR)
      else $error("High-resolution mode did not decimate by 128.");
   chk_settle_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $rose(settled_o) |-> h_dec == (tk.hr ? SETTLE_HR : SETTLE_STD))
      else $error("Settled flag rose after the wrong number of words.");
   chk_realign_halt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !st_reg.rl_s2 |=> !st_reg.tick && st_reg.div_cnt == 6'h00 && !settled_o)
      else $error("Realign did not halt conversion.");
   chk_mode_unsettle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      changed |=> !settled_o ##1 !data_valid_o)
      else $error("Mode change did not restart settling.");
   chk_tick_width: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      st_reg.tick |=> !st_reg.tick [*3])
      else $error("Sample strobes closer than one modulator period.");
   chk_valid_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      data_valid_o |-> $past(st_reg.dec) && !$past(clr))
      else $error("Output strobe without a shared decimation strobe.");

   cov_hr_word: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      data_valid_o && tk.hr);
   cov_settled: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(settled_o));
   cov_slow_div: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      st_reg.tick && div_sel == DIV_SLOW);
endmodule : mdf_top
`default_nettype wire

//--- dv/mdf_mod_model.sv
// Behavioural modulators that feed fixed and random bit streams.
`timescale 1ns/1ps
`default_nettype none
module mdf_mod_model (
   input wire logic mod_clk_i,
   input wire logic rnd_i,
   output logic [mdf_pkg::NUM_CHAN-1:0] bits_o
);
   import mdf_pkg::*;
   logic alt_reg = 1'b0;
   logic rnd_reg = 1'b0;
   // Each modulator emits one new bit per modulator period.
   always @(posedge mod_clk_i) begin
      alt_reg <= ~alt_reg;
      rnd_reg <= rnd_i;
   end
   // Channel 0 is full positive, 1 full negative, 2 alternating at half density for a zero mean, the rest share a random bit.
   always_comb begin
      bits_o = {NUM_CHAN{rnd_reg}};
      bits_o[0] = 1'b1;
      bits_o[1] = 1'b0;
      bits_o[2] = alt_reg;
   end
endmodule : mdf_mod_model
`default_nettype wire

//--- dv/mdf_top_bench.sv
// Self-checking bench for the multichannel decimation filter.
`timescale 1ns/1ps
`default_nettype none
module mdf_top_bench;
   import mdf_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [1:0] mode_i = 2'h0;
   logic sel_i = 1'b1;
   logic realign_n_i = 1'b1;
   logic rnd = 1'b0;
   logic [NUM_CHAN-1:0] bits;
   logic mod_clk;
   logic [NUM_CHAN-1:0][WORD_W-1:0] data;
   logic valid;
   logic settled;
   logic [31:0] seed = 32'h00012889;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   mdf_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
      .clock_divide_select_i(sel_i), .realign_n_i(realign_n_i), .mod_bits_i(bits),
      .mod_clk_o(mod_clk), .data_o(data), .data_valid_o(valid), .settled_o(settled));
   mdf_mod_model modl (.mod_clk_i(mod_clk), .rnd_i(rnd), .bits_o(bits));

   always #5 clk_i = ~clk_i;

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction : xs

   function automatic logic [23:0] exp_div(input logic [1:0] m, input logic s);
      if (m == 2'h2) return s ? 24'h8 : 24'h4;
      if (m == 2'h3) return s ? 24'h28 : 24'h8;
      return 24'h4;
   endfunction : exp_div

   function automatic logic [23:0] exp_osr(input logic [1:0] m);
      return (m == 2'h1) ? 24'h80 : 24'h40;
   endfunction : exp_osr

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   always @(negedge clk_i) begin
      seed <= xs(seed);
      rnd <= seed[0];
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         stop_test();
      end
   end

   // Sets a mode, realigns, then measures rates, settling and words.
   task automatic run(input logic [1:0] m, input logic s, input int np);
      time t0;
      time t1;
      int k;
      @(negedge clk_i);
      mode_i = m;
      sel_i = s;
      repeat (5) @(negedge clk_i);
      chk({23'h0, settled}, 24'h0);
      realign_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      repeat (8 + seed[2:0]) @(negedge clk_i) chk({23'h0, valid | settled}, 24'h0);
      realign_n_i = 1'b1;
      @(posedge mod_clk);
      t0 = $time;
      @(posedge mod_clk);
      chk(24'(($time - t0) / 10), exp_div(m, s));
      t1 = $time;
      for (k = 1; k <= np; k++) begin
         @(posedge valid);
         #1;
         if (k > 1) chk(24'(($time - t1) / 10), exp_div(m, s) * exp_osr(m));
         t1 = $time;
         chk({23'h0, settled}, {23'h0, k >= (m == 2'h1 ? 78 : 76)});
         chk(data[3], data[4]);
      end
      if (np > 70) begin
         chk(data[0], POS_FULL);
         chk(data[1], NEG_FULL);
         chk(data[2], 24'h000000);
      end
      $display("test done: mode %h select %h", m, s);
   endtask : run

   initial begin
      repeat (5) @(negedge clk_i);
      reset_n_i = 1'b1;
      run(2'h0, 1'b1, 76);
      run(2'h1, 1'b1, 78);
      for (int i = 0; i < 8; i++) begin
         run(i[2:1], ~i[0], 3);
      end
      stop_test();
   end
endmodule : mdf_top_bench
`default_nettype wire

//--- pkg/mdf_pkg.sv
// Shared constants and types of the multichannel decimation filter.
package mdf_pkg;
   localparam int NUM_CHAN = 8;
   localparam int WORD_W = 24;
   localparam int ACC_W = 26;
   typedef enum logic [1:0] {
      MODE_HIGH_SPEED = 2'h0,
      MODE_HIGH_RES = 2'h1,
      MODE_LOW_POWER = 2'h2,
      MODE_LOW_SPEED = 2'h3
   } mdf_mode_t;
   typedef enum logic [1:0] {
      ST_HALT = 2'h0,
      ST_SETTLING = 2'h1,
      ST_SETTLED = 2'h3
   } mdf_phase_t;
   localparam logic [5:0] DIV_FAST = 6'h04;
   localparam logic [5:0] DIV_MID = 6'h08;
   localparam logic [5:0] DIV_SLOW = 6'h28;
   localparam logic [7:0] OSR_STD = 8'h40;
   localparam logic [7:0] OSR_HR = 8'h80;
   localparam logic [6:0] SETTLE_STD = 7'h4C;
   localparam logic [6:0] SETTLE_HR = 7'h4E;
   localparam int SHIFT_STD = 5;
   localparam int SHIFT_HR = 2;
   localparam logic [WORD_W-1:0] POS_FULL = 24'h7FFFFF;
   localparam logic [WORD_W-1:0] NEG_FULL = 24'h800000;
endpackage : mdf_pkg

//--- pkg/mdf_tick_if.sv
// Shared filter timing carried from the controller to each channel.
`timescale 1ns/1ps
`default_nettype none
interface mdf_tick_if;
   logic tick;
   logic dec;
   logic clr;
   logic hr;
   modport ctrl (output tick, output dec, output clr, output hr);
   modport chan (input tick, input dec, input clr, input hr);
endinterface : mdf_tick_if
`default_nettype wire
